// [common/hbp_pkg.sv]
package hbp_pkg;
  // Port decode on {port_select_high, port_select_low}.
  localparam logic [1:0] PORT_HOST_DATA = 2'h0;
  localparam logic [1:0] PORT_HOST_CMD = 2'h1;
  localparam logic [1:0] PORT_DEV_DATA = 2'h2;
  localparam logic [1:0] PORT_DEV_CMD = 2'h3;
  // Register indices as read; the write index sets the top bit of the command.
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [6:0] IDX_DMA_SETUP = 7'h21;
  localparam logic [6:0] IDX_XFER_COUNT = 7'h22;
  localparam logic [6:0] IDX_CHIP_ID = 7'h27;
  localparam logic [6:0] IDX_WIDE_SCRATCH = 7'h2F;
  localparam logic [6:0] IDX_HOST_BUFFER = 7'h40;
  // Fields of dma_setup.
  localparam int SETUP_DMA_EN_BIT = 0;
  localparam int SETUP_DIR_WRITE_BIT = 1;
  localparam int SETUP_COUNTER_SEL_BIT = 2;
  localparam logic [15:0] SETUP_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
  // Arbitrary identity value.
  localparam logic [15:0] CHIP_ID_DEFAULT = 16'hA5C3;
  localparam logic [15:0] BYTES_PER_WORD = 16'h0002;
  localparam int DEFAULT_BUF_WORDS = 2048;
  // Layout of the synchronised pin vector.
  localparam int SY_CS_N = 0;
  localparam int SY_RD_N = 1;
  localparam int SY_WR_N = 2;
  localparam int SY_A0 = 3;
  localparam int SY_A1 = 4;
  localparam int SY_ACK1_N = 5;
  localparam int SY_ACK2_N = 6;
  localparam int SY_END_N = 7;
  localparam int SY_DATA = 8;
  localparam int SY_W = 24;
  localparam logic [23:0] SY_IDLE = 24'h0000E7;
endpackage : hbp_pkg

// [core/hbp_port.sv]
// How it works
// [R1] 16-bit bus, two address lines, four ports.
// [R2] Address 00,01,10,11 pick host/device data/command.
// [R3] Read drives data ports; command ports write only.
// [R4] Write strobe captures command or data word.
// [R5] Command index is low byte of bus.
// [R6] Index write then data phase on data port.
// [R7] Wide register: low half first, then high.
// [R8] Host chip identity readable at index 27H.
// [R9] Buffer access stops at half the byte count.
// [R10] Byte count register read 22H, written A2H.
// [R11] Processor keeps one direction per buffer cycle.
// [R12] Two DMA channels, host and device half.
// [R13] External DMA controller masters; device is target.
// [R14] External end input stops running DMA.
// [R15] Enabled counter ends DMA at byte count.
// [R16] Request raised per burst, acknowledged strobes follow.
// [R17] Each data word advances the buffer pointer.
`timescale 1ns/1ns
`default_nettype none
module hbp_port #(
  parameter int BUF_WORDS = hbp_pkg::DEFAULT_BUF_WORDS,
  parameter logic [15:0] CHIP_ID = hbp_pkg::CHIP_ID_DEFAULT
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Processor bus pins.
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic port_select_low_i,
  input wire logic port_select_high_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_n_o,
  // DMA pins.
  output logic host_dma_request_o,
  input wire logic host_dma_ack_n_i,
  output logic dev_dma_request_o,
  input wire logic dev_dma_ack_n_i,
  input wire logic transfer_end_n_i,
  // Peripheral half user side.
  input wire logic dev_dma_req_i,
  input wire logic [15:0] dev_rd_data_i,
  output logic [7:0] dev_cmd_o,
  output logic dev_cmd_valid_o,
  output logic [15:0] dev_wr_data_o,
  output logic dev_wr_valid_o,
  output logic dev_rd_done_o,
  output logic dev_dma_end_o
);
  localparam int PW = $clog2(BUF_WORDS);

  if (BUF_WORDS < 2 || (BUF_WORDS & (BUF_WORDS - 1)) != 0) begin : g_bad_size
    $error("BUF_WORDS must be a power of two of at least 2");
  end

  logic [hbp_pkg::SY_W-1:0] sy1_reg, sy2_reg, sy3_reg;
  logic [15:0] mem [BUF_WORDS];
  logic [7:0] cmd_reg, cmd_next, dev_cmd_reg, dev_cmd_next;
  logic [15:0] setup_reg, setup_next, count_reg, count_next, words_reg, words_next;
  logic [15:0] dma_bytes_reg, dma_bytes_next, data_reg, data_next, dev_wd_reg, dev_wd_next;
  logic [31:0] scratch_reg, scratch_next;
  logic [PW-1:0] ptr_reg, ptr_next;
  logic wide_hi_reg, wide_hi_next, buf_active_reg, buf_active_next, oe_n_reg, oe_n_next;
  logic dev_req_reg, dev_cmd_v_reg, dev_cmd_v_next, dev_wv_reg, dev_wv_next;
  logic dev_rdd_reg, dev_rdd_next, dev_end_reg, dev_end_next;

  // Levels seen while the strobe was still low, and strobe release events.
  logic [1:0] sel_now, sel_hold;
  logic rd_end, wr_end, acc_end, host_pio, host_dma, dev_pio, dev_dma, idx_write;
  logic [6:0] idx;
  logic [15:0] wdata;
  logic buf_ok, buf_last, dma_word, dma_stop, dma_cnt_hit;

  // Every pin passes two flip-flops; the third stage serves edge detection and holds the levels seen while the strobe was still low.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sy1_reg <= hbp_pkg::SY_IDLE;
      sy2_reg <= hbp_pkg::SY_IDLE;
      sy3_reg <= hbp_pkg::SY_IDLE;
    end else begin
      sy1_reg <= {data_i, transfer_end_n_i, dev_dma_ack_n_i, host_dma_ack_n_i,
                  port_select_high_i, port_select_low_i, wr_n_i, rd_n_i, cs_n_i};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  always_comb begin
    sel_now = {sy2_reg[hbp_pkg::SY_A1], sy2_reg[hbp_pkg::SY_A0]}; // [R1]
    sel_hold = {sy3_reg[hbp_pkg::SY_A1], sy3_reg[hbp_pkg::SY_A0]};
    rd_end = !sy3_reg[hbp_pkg::SY_RD_N] && sy2_reg[hbp_pkg::SY_RD_N];
    wr_end = !sy3_reg[hbp_pkg::SY_WR_N] && sy2_reg[hbp_pkg::SY_WR_N];
    acc_end = rd_end || wr_end;
    // DMA cycles are selected by acknowledge rather than chip select.
    host_dma = !sy3_reg[hbp_pkg::SY_ACK1_N]; // [R13]
    dev_dma = !sy3_reg[hbp_pkg::SY_ACK2_N]; // [R12]
    host_pio = !sy3_reg[hbp_pkg::SY_CS_N] && sel_hold == hbp_pkg::PORT_HOST_DATA; // [R2]
    dev_pio = !sy3_reg[hbp_pkg::SY_CS_N] && sel_hold == hbp_pkg::PORT_DEV_DATA; // [R2]
    idx = cmd_reg[6:0];
    idx_write = cmd_reg[hbp_pkg::CMD_WRITE_BIT];
    wdata = sy3_reg[hbp_pkg::SY_DATA +: 16];
    // A read command only honours reads and a write command only writes.
    buf_ok = host_pio && !host_dma && idx == hbp_pkg::IDX_HOST_BUFFER && buf_active_reg &&
             ((wr_end && idx_write) || (rd_end && !idx_write)); // [R11]
    // Built from register values only, so the two decode processes never feed each other.
    buf_last = (words_reg + 16'h0001) == {1'b0, count_reg[15:1]};
    dma_word = host_dma && setup_reg[hbp_pkg::SETUP_DMA_EN_BIT] &&
               (setup_reg[hbp_pkg::SETUP_DIR_WRITE_BIT] ? wr_end : rd_end); // [R16]
    dma_cnt_hit = setup_reg[hbp_pkg::SETUP_COUNTER_SEL_BIT] &&
                  dma_word && (dma_bytes_reg + hbp_pkg::BYTES_PER_WORD) >= count_reg; // [R15]
    dma_stop = dma_cnt_hit || (!sy2_reg[hbp_pkg::SY_END_N] && host_dma); // [R14]
  end

  always_comb begin
    cmd_next = cmd_reg;
    wide_hi_next = wide_hi_reg;
    setup_next = setup_reg;
    count_next = count_reg;
    scratch_next = scratch_reg;
    ptr_next = ptr_reg;
    words_next = words_reg;
    buf_active_next = buf_active_reg;
    dma_bytes_next = dma_bytes_reg;
    if (wr_end && !sy3_reg[hbp_pkg::SY_CS_N] && sel_hold == hbp_pkg::PORT_HOST_CMD) begin
      // Only the low byte carries the index; the high byte is expected zero.
      cmd_next = wdata[7:0]; // [R4] [R5] [R6]
      wide_hi_next = 1'b0;
      buf_active_next = 1'b0;
      if (wdata[6:0] == hbp_pkg::IDX_HOST_BUFFER) begin
        ptr_next = '0;
        words_next = 16'h0000;
        buf_active_next = count_reg[15:1] != 15'h0000;
      end
    end else if (acc_end && host_pio && !host_dma) begin
      if (idx == hbp_pkg::IDX_WIDE_SCRATCH) begin
        wide_hi_next = !wide_hi_reg; // [R7]
      end
      if (wr_end && idx_write) begin
        unique case (idx)
          hbp_pkg::IDX_DMA_SETUP: setup_next = wdata;
          hbp_pkg::IDX_XFER_COUNT: count_next = wdata; // [R10]
          hbp_pkg::IDX_WIDE_SCRATCH: begin
            if (wide_hi_reg) begin
              scratch_next[31:16] = wdata; // [R7]
            end else begin
              scratch_next[15:0] = wdata; // [R7]
            end
          end
          default: ;
        endcase
      end
      if (buf_ok) begin
        ptr_next = ptr_reg + 1'b1; // [R17]
        words_next = words_reg + 16'h0001;
        buf_active_next = !buf_last; // [R9]
      end
    end
    if (setup_next[hbp_pkg::SETUP_DMA_EN_BIT] && !setup_reg[hbp_pkg::SETUP_DMA_EN_BIT]) begin
      ptr_next = '0;
      dma_bytes_next = 16'h0000;
    end
    if (dma_word) begin
      ptr_next = ptr_reg + 1'b1; // [R17]
      dma_bytes_next = dma_bytes_reg + hbp_pkg::BYTES_PER_WORD;
    end
    if (dma_stop && setup_reg[hbp_pkg::SETUP_DMA_EN_BIT]) begin
      setup_next[hbp_pkg::SETUP_DMA_EN_BIT] = 1'b0; // [R14] [R15]
    end
  end

  // Read data is prepared every cycle so it is on the bus while the strobe is low.
  always_comb begin
    data_next = data_reg;
    oe_n_next = 1'b1;
    if (!sy2_reg[hbp_pkg::SY_RD_N]) begin
      if (!sy2_reg[hbp_pkg::SY_ACK1_N]) begin
        data_next = mem[ptr_reg];
        oe_n_next = 1'b0;
      end else if (!sy2_reg[hbp_pkg::SY_ACK2_N] ||
                   (!sy2_reg[hbp_pkg::SY_CS_N] && sel_now == hbp_pkg::PORT_DEV_DATA)) begin
        data_next = dev_rd_data_i;
        oe_n_next = 1'b0; // [R3]
      end else if (!sy2_reg[hbp_pkg::SY_CS_N] && sel_now == hbp_pkg::PORT_HOST_DATA) begin
        oe_n_next = 1'b0; // [R3]
        unique case (idx)
          hbp_pkg::IDX_DMA_SETUP: data_next = setup_reg;
          hbp_pkg::IDX_XFER_COUNT: data_next = count_reg; // [R10]
          hbp_pkg::IDX_CHIP_ID: data_next = CHIP_ID; // [R8]
          hbp_pkg::IDX_WIDE_SCRATCH: data_next = wide_hi_reg ? scratch_reg[31:16] :
                                                               scratch_reg[15:0]; // [R7]
          hbp_pkg::IDX_HOST_BUFFER: data_next = mem[ptr_reg];
          default: data_next = 16'h0000;
        endcase
      end
    end
  end

  // The peripheral half sees decoded strobes; its registers live elsewhere.
  always_comb begin
    dev_cmd_next = dev_cmd_reg;
    dev_wd_next = dev_wd_reg;
    dev_cmd_v_next = 1'b0;
    dev_wv_next = 1'b0;
    dev_rdd_next = rd_end && (dev_pio || dev_dma);
    dev_end_next = dev_dma && !sy2_reg[hbp_pkg::SY_END_N] && sy3_reg[hbp_pkg::SY_END_N]; // [R14]
    if (wr_end && !sy3_reg[hbp_pkg::SY_CS_N] && sel_hold == hbp_pkg::PORT_DEV_CMD) begin
      dev_cmd_next = wdata[7:0]; // [R5]
      dev_cmd_v_next = 1'b1; // [R4]
    end
    if (wr_end && (dev_pio || dev_dma)) begin
      dev_wd_next = wdata;
      dev_wv_next = 1'b1; // [R4]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmd_reg <= 8'h00;
      wide_hi_reg <= 1'b0;
      setup_reg <= hbp_pkg::SETUP_RESET;
      count_reg <= hbp_pkg::COUNT_RESET;
      scratch_reg <= hbp_pkg::SCRATCH_RESET;
      ptr_reg <= '0;
      words_reg <= 16'h0000;
      buf_active_reg <= 1'b0;
      dma_bytes_reg <= 16'h0000;
      data_reg <= 16'h0000;
      oe_n_reg <= 1'b1;
      dev_req_reg <= 1'b0;
      dev_cmd_reg <= 8'h00;
      dev_cmd_v_reg <= 1'b0;
      dev_wd_reg <= 16'h0000;
      dev_wv_reg <= 1'b0;
      dev_rdd_reg <= 1'b0;
      dev_end_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      wide_hi_reg <= wide_hi_next;
      setup_reg <= setup_next;
      count_reg <= count_next;
      scratch_reg <= scratch_next;
      ptr_reg <= ptr_next;
      words_reg <= words_next;
      buf_active_reg <= buf_active_next;
      dma_bytes_reg <= dma_bytes_next;
      data_reg <= data_next;
      oe_n_reg <= oe_n_next;
      dev_req_reg <= dev_dma_req_i; // [R12]
      dev_cmd_reg <= dev_cmd_next;
      dev_cmd_v_reg <= dev_cmd_v_next;
      dev_wd_reg <= dev_wd_next;
      dev_wv_reg <= dev_wv_next;
      dev_rdd_reg <= dev_rdd_next;
      dev_end_reg <= dev_end_next;
    end
  end

  // Buffer storage has no reset; its contents are undefined until written.
  always_ff @(posedge clk_i) begin
    if ((buf_ok && wr_end) || (dma_word && wr_end)) begin
      mem[ptr_reg] <= wdata; // [R17]
    end
  end

  assign data_o = data_reg;
  assign data_oe_n_o = oe_n_reg;
  assign host_dma_request_o = setup_reg[hbp_pkg::SETUP_DMA_EN_BIT]; // [R16]
  assign dev_dma_request_o = dev_req_reg;
  assign dev_cmd_o = dev_cmd_reg;
  assign dev_cmd_valid_o = dev_cmd_v_reg;
  assign dev_wr_data_o = dev_wd_reg;
  assign dev_wr_valid_o = dev_wv_reg;
  assign dev_rd_done_o = dev_rdd_reg;
  assign dev_dma_end_o = dev_end_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_read_drives;
    !sy2_reg[hbp_pkg::SY_RD_N] && !sy2_reg[hbp_pkg::SY_CS_N] &&
      sel_now == hbp_pkg::PORT_HOST_DATA |=> !data_oe_n_o;
  endproperty
  a_read_drives: assert property (p_read_drives) else $error("data port read not driven"); // [R3]
  property p_cmd_no_drive;
    !sy2_reg[hbp_pkg::SY_RD_N] && !sy2_reg[hbp_pkg::SY_CS_N] && sel_now[0] &&
      sy2_reg[hbp_pkg::SY_ACK1_N] && sy2_reg[hbp_pkg::SY_ACK2_N] |=> data_oe_n_o;
  endproperty
  a_cmd_no_drive: assert property (p_cmd_no_drive) else $error("command port drove bus"); // [R3]
  property p_cmd_capture;
    wr_end && !sy3_reg[hbp_pkg::SY_CS_N] && sel_hold == hbp_pkg::PORT_HOST_CMD
      |=> cmd_reg == $past(wdata[7:0]);
  endproperty
  a_cmd_capture: assert property (p_cmd_capture) else $error("command not captured"); // [R5]
  property p_chip_id;
    cmd_reg[6:0] == hbp_pkg::IDX_CHIP_ID && !sy2_reg[hbp_pkg::SY_RD_N] &&
      !sy2_reg[hbp_pkg::SY_CS_N] && sel_now == hbp_pkg::PORT_HOST_DATA &&
      sy2_reg[hbp_pkg::SY_ACK1_N] && sy2_reg[hbp_pkg::SY_ACK2_N] |=> data_o == CHIP_ID;
  endproperty
  a_chip_id: assert property (p_chip_id) else $error("chip identity wrong"); // [R8]
  property p_wide_half;
    acc_end && host_pio && !host_dma && idx == hbp_pkg::IDX_WIDE_SCRATCH && !wr_end
      |=> wide_hi_reg != $past(wide_hi_reg);
  endproperty
  a_wide_half: assert property (p_wide_half) else $error("wide half did not advance"); // [R7]
  property p_ptr_step;
    buf_ok && !dma_word |=> ptr_reg == $past(ptr_reg) + 1'b1;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance"); // [R17]
  property p_word_limit;
    buf_active_reg |-> words_reg < {1'b0, count_reg[15:1]};
  endproperty
  a_word_limit: assert property (p_word_limit) else $error("buffer overran byte count"); // [R9]
  property p_ext_end;
    host_dma_request_o && host_dma && !sy2_reg[hbp_pkg::SY_END_N] |=> !host_dma_request_o;
  endproperty
  a_ext_end: assert property (p_ext_end) else $error("external end ignored"); // [R14]
  property p_cnt_end;
    dma_cnt_hit |=> !host_dma_request_o ##1 dma_bytes_reg >= count_reg;
  endproperty
  a_cnt_end: assert property (p_cnt_end) else $error("counter end failed"); // [R15]
  property p_req_on;
    wr_end && host_pio && !host_dma && cmd_reg == {1'b1, hbp_pkg::IDX_DMA_SETUP} &&
      wdata[hbp_pkg::SETUP_DMA_EN_BIT] |=> host_dma_request_o;
  endproperty
  a_req_on: assert property (p_req_on) else $error("request not raised"); // [R16]

  c_id_read: cover property (cmd_reg[6:0] == hbp_pkg::IDX_CHIP_ID && rd_end && host_pio);
  c_cnt_end: cover property (dma_cnt_hit);
  c_buf_done: cover property (buf_ok && buf_last);
  c_dev_cmd: cover property (dev_cmd_v_reg);
endmodule : hbp_port
`default_nettype wire

// [dv/hbp_cpu_model.sv]
`timescale 1ns/1ns
`default_nettype none
module hbp_cpu_model (
  // Clock.
  input wire logic clk_i,
  // Pins towards the port.
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [1:0] sel_o,
  output logic [15:0] bus_o,
  output logic ack1_n_o,
  output logic ack2_n_o,
  output logic end_n_o,
  // Port drive seen on the shared bus.
  input wire logic [15:0] dut_data_i,
  input wire logic dut_oe_n_i
);
  logic [15:0] drv_val;
  logic drv_en;
  // A released bus shows the inverse of the last word, so stale data never passes for fresh.
  assign bus_o = !dut_oe_n_i ? dut_data_i : (drv_en ? drv_val : ~drv_val);
  initial begin
    {cs_n_o, rd_n_o, wr_n_o, ack1_n_o, ack2_n_o, end_n_o} = 6'h3F;
    sel_o = 2'h0;
    drv_val = 16'h0000;
    drv_en = 1'b0;
  end
  // Strobe stands 7 clocks low and 6 high, above the 4 that the port needs.
  task automatic cycle(input logic [1:0] sel, input logic wr, input logic dma,
                       input logic [15:0] val, output logic [15:0] rd, output logic oe);
    @(posedge clk_i);
    sel_o <= sel;
    cs_n_o <= dma;
    drv_val <= wr ? val : drv_val;
    drv_en <= wr;
    wr_n_o <= !wr;
    rd_n_o <= wr;
    repeat (6) @(posedge clk_i);
    #1;
    rd = bus_o;
    oe = dut_oe_n_i;
    @(posedge clk_i);
    {wr_n_o, rd_n_o, cs_n_o, drv_en} <= 4'hE;
    repeat (5) @(posedge clk_i);
  endtask : cycle
  task automatic cmd(input logic side, input logic [7:0] code);
    logic [15:0] d;
    logic o;
    cycle({side, 1'b1}, 1'b1, 1'b0, {8'h00, code}, d, o);
  endtask : cmd
  task automatic reg_write(input logic [7:0] code, input logic [15:0] val);
    logic [15:0] d;
    logic o;
    cmd(1'b0, code);
    cycle(2'h0, 1'b1, 1'b0, val, d, o);
  endtask : reg_write
  task automatic reg_read(input logic [7:0] code, output logic [15:0] val);
    logic o;
    cmd(1'b0, code);
    cycle(2'h0, 1'b0, 1'b0, 16'h0000, val, o);
  endtask : reg_read
  task automatic dma_hold(input logic ch2, input logic on);
    @(posedge clk_i);
    if (ch2) ack2_n_o <= !on;
    else ack1_n_o <= !on;
  endtask : dma_hold
  task automatic dma_end();
    @(posedge clk_i);
    end_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    end_n_o <= 1'b1;
  endtask : dma_end
endmodule : hbp_cpu_model
`default_nettype wire

// [dv/host_bus_command_data_port_test.sv]
`timescale 1ns/1ns
`default_nettype none
module host_bus_command_data_port_test;
  logic clk_i, rst_n_i, cs_n, rd_n, wr_n, ack1_n, ack2_n, end_n, oe_n, oe;
  logic host_req, dev_req, dev_req_in, cmd_v, wr_v, rd_done, dma_end;
  logic [1:0] sel;
  logic [15:0] bus, dout, dev_rd, dev_wd, v, w, lo, hi;
  logic [7:0] dev_cmd, b;
  logic [15:0] ref_mem [0:15];
  logic [3:0] n_cmd, n_wr, n_rd, n_end;
  int errors, cmp_count, cycles, seed;
  hbp_port #(.BUF_WORDS(16)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .port_select_low_i(sel[0]), .port_select_high_i(sel[1]),
    .data_i(bus), .data_o(dout), .data_oe_n_o(oe_n), .host_dma_request_o(host_req),
    .host_dma_ack_n_i(ack1_n), .dev_dma_request_o(dev_req), .dev_dma_ack_n_i(ack2_n),
    .transfer_end_n_i(end_n), .dev_dma_req_i(dev_req_in), .dev_rd_data_i(dev_rd),
    .dev_cmd_o(dev_cmd), .dev_cmd_valid_o(cmd_v), .dev_wr_data_o(dev_wd),
    .dev_wr_valid_o(wr_v), .dev_rd_done_o(rd_done), .dev_dma_end_o(dma_end));
  hbp_cpu_model cpu (.clk_i(clk_i), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .sel_o(sel), .bus_o(bus), .ack1_n_o(ack1_n), .ack2_n_o(ack2_n), .end_n_o(end_n),
    .dut_data_i(dout), .dut_oe_n_i(oe_n));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  function automatic logic [7:0] wr_idx(input logic [6:0] idx);
    return {1'b1, idx};
  endfunction : wr_idx
  function automatic int words_for(input logic [15:0] count);
    return int'(count / hbp_pkg::BYTES_PER_WORD);
  endfunction : words_for
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // Pulse counters show that each user-side strobe fires exactly once.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
    if (!rst_n_i) {n_cmd, n_wr, n_rd, n_end} <= 16'h0000;
    else begin
      n_cmd <= n_cmd + {3'h0, cmd_v};
      n_wr <= n_wr + {3'h0, wr_v};
      n_rd <= n_rd + {3'h0, rd_done};
      n_end <= n_end + {3'h0, dma_end};
    end
  end
  initial begin
    {errors, cmp_count, cycles} = '0;
    rst_n_i = 1'b0;
    dev_req_in = 1'b0;
    dev_rd = 16'h0000;
    seed = $urandom(43);
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({13'h0000, oe_n, host_req, dev_req}, 16'h0004);
    cpu.reg_read({1'b0, hbp_pkg::IDX_DMA_SETUP}, v);
    check(v, hbp_pkg::SETUP_RESET);
    cpu.reg_read({1'b0, hbp_pkg::IDX_XFER_COUNT}, v);
    check(v, hbp_pkg::COUNT_RESET);
    cpu.reg_write(wr_idx(hbp_pkg::IDX_CHIP_ID), 16'($urandom));
    cpu.reg_read({1'b0, hbp_pkg::IDX_CHIP_ID}, v);
    check(v, hbp_pkg::CHIP_ID_DEFAULT);
    cpu.reg_read(8'h30, v);
    check(v, 16'h0000);
    for (int s = 1; s < 4; s += 2) begin
      cpu.cycle(s[1:0], 1'b0, 1'b0, 16'h0000, v, oe);
      check({15'h0000, oe}, 16'h0001);
    end
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 16'hFFFF : 16'($urandom);
      cpu.reg_write(wr_idx(hbp_pkg::IDX_XFER_COUNT), w);
      cpu.reg_read({1'b0, hbp_pkg::IDX_XFER_COUNT}, v);
      check(v, w);
    end
    lo = 16'($urandom);
    hi = 16'($urandom);
    cpu.reg_write(wr_idx(hbp_pkg::IDX_WIDE_SCRATCH), lo);
    cpu.cycle(2'h0, 1'b1, 1'b0, hi, v, oe);
    cpu.reg_read({1'b0, hbp_pkg::IDX_WIDE_SCRATCH}, v);
    check(v, lo);
    cpu.cycle(2'h0, 1'b0, 1'b0, 16'h0000, v, oe);
    check(v, hi);
    // The second pass writes one word too many; that word must not land.
    for (int c = 10; c >= 8; c -= 2) begin
      cpu.reg_write(wr_idx(hbp_pkg::IDX_XFER_COUNT), 16'(c));
      cpu.cmd(1'b0, wr_idx(hbp_pkg::IDX_HOST_BUFFER));
      for (int i = 0; i < 5; i++) begin
        w = 16'($urandom);
        if (i < words_for(16'(c))) ref_mem[i] = w;
        cpu.cycle(2'h0, 1'b1, 1'b0, w, v, oe);
      end
    end
    cpu.reg_write(wr_idx(hbp_pkg::IDX_XFER_COUNT), 16'h000A);
    cpu.cmd(1'b0, {1'b0, hbp_pkg::IDX_HOST_BUFFER});
    for (int i = 0; i < 5; i++) begin
      cpu.cycle(2'h0, 1'b0, 1'b0, 16'h0000, v, oe);
      check(v, ref_mem[i]);
    end
    cpu.reg_write(wr_idx(hbp_pkg::IDX_XFER_COUNT), 16'h0004);
    cpu.reg_write(wr_idx(hbp_pkg::IDX_DMA_SETUP), 16'h0005);
    check({15'h0000, host_req}, 16'h0001);
    cpu.dma_hold(1'b0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      check({15'h0000, host_req}, 16'h0001);
      cpu.cycle(2'h0, 1'b0, 1'b1, 16'h0000, v, oe);
      check(v, ref_mem[i]);
    end
    check({15'h0000, host_req}, 16'h0000);
    cpu.dma_hold(1'b0, 1'b0);
    cpu.reg_read({1'b0, hbp_pkg::IDX_DMA_SETUP}, v);
    check(v, 16'h0004);
    cpu.reg_write(wr_idx(hbp_pkg::IDX_DMA_SETUP), 16'h0003);
    cpu.dma_hold(1'b0, 1'b1);
    w = 16'($urandom);
    cpu.cycle(2'h0, 1'b1, 1'b1, w, v, oe);
    check({15'h0000, host_req}, 16'h0001);
    cpu.dma_end();
    repeat (4) @(posedge clk_i);
    check({15'h0000, host_req}, 16'h0000);
    cpu.dma_hold(1'b0, 1'b0);
    cpu.reg_write(wr_idx(hbp_pkg::IDX_XFER_COUNT), 16'h0002);
    cpu.cmd(1'b0, {1'b0, hbp_pkg::IDX_HOST_BUFFER});
    cpu.cycle(2'h0, 1'b0, 1'b0, 16'h0000, v, oe);
    check(v, w);
    b = 8'($urandom);
    cpu.cmd(1'b1, b);
    check({8'h00, dev_cmd}, {8'h00, b});
    w = 16'($urandom);
    cpu.cycle(2'h2, 1'b1, 1'b0, w, v, oe);
    check(dev_wd, w);
    dev_rd <= 16'($urandom);
    dev_req_in <= 1'b1;
    cpu.cycle(2'h2, 1'b0, 1'b0, 16'h0000, v, oe);
    check(v, dev_rd);
    check({15'h0000, dev_req}, 16'h0001);
    cpu.dma_hold(1'b1, 1'b1);
    cpu.dma_end();
    cpu.dma_hold(1'b1, 1'b0);
    repeat (4) @(posedge clk_i);
    check({n_cmd, n_wr, n_rd, n_end}, 16'h1111);
    give_verdict();
  end
endmodule : host_bus_command_data_port_test
`default_nettype wire
